/* File: core/tla_pkg.sv */
// Constants, types and helpers shared by the thermal limit alarm register block
package tla_pkg;

   // ==========================================================================
   // Register indices (byte address is four times the index)
   localparam int TLA_ADDR_W = 9;
   localparam int TLA_NUM_CH = 2;
   localparam logic [6:0] TLA_IDX_BANK_SEL = 7'h4E;
   localparam logic [6:0] TLA_IDX_READ_HI = 7'h50;
   localparam logic [6:0] TLA_IDX_READ_LO = 7'h51;
   localparam logic [6:0] TLA_IDX_CFG = 7'h52;
   localparam logic [6:0] TLA_IDX_HYST_HI = 7'h53;
   localparam logic [6:0] TLA_IDX_HYST_LO = 7'h54;
   localparam logic [6:0] TLA_IDX_OVT_HI = 7'h55;
   localparam logic [6:0] TLA_IDX_OVT_LO = 7'h56;
   localparam logic [6:0] TLA_IDX_EVT_STATUS = 7'h50;
   localparam logic [6:0] TLA_IDX_SMI_MASK = 7'h51;
   localparam logic [6:0] TLA_IDX_ALARM3 = 7'h53;
   localparam logic [6:0] TLA_IDX_ALARM2 = 7'h57;

   // ==========================================================================
   // Banks behind the window
   localparam logic [2:0] TLA_BANK_GLOBAL = 3'h0;
   localparam logic [2:0] TLA_BANK_CPU = 3'h1;
   localparam logic [2:0] TLA_BANK_AUX = 3'h2;
   localparam logic [2:0] TLA_BANK_EVENT = 3'h4;

   // ==========================================================================
   // Field positions
   localparam int TLA_CFG_STOP_BIT = 0;
   localparam int TLA_CFG_MODE_BIT = 1;
   localparam int TLA_CFG_FAULT_LSB = 3;
   localparam int TLA_LO_BYTE_BIT = 7;
   localparam int TLA_EVT_SB_BIT = 0;
   localparam int TLA_EVT_BAT_BIT = 1;
   localparam int TLA_EVT_FAN_BIT = 2;
   localparam int TLA_MASK_FAN_BIT = 4;
   localparam int TLA_ALARM_SB_BIT = 0;
   localparam int TLA_ALARM_BAT_BIT = 1;
   localparam int TLA_ALARM_USER_BIT = 5;
   localparam int TLA_ALARM_GLOBAL_BIT = 7;

   // ==========================================================================
   // Reset values
   localparam logic [8:0] TLA_READING_RST = 9'h000;
   localparam logic [8:0] TLA_HYST_RST = 9'h096;
   localparam logic [8:0] TLA_OVT_RST = 9'h0A0;
   localparam logic [3:0] TLA_CFG_RST = 4'h0;
   localparam logic [2:0] TLA_BANK_RST = 3'h0;
   localparam logic [2:0] TLA_STATUS_RST = 3'h0;
   localparam logic [2:0] TLA_MASK_RST = 3'h7;
   localparam logic TLA_GLOBAL_RST = 1'b1;
   localparam logic [1:0] TLA_RESP_OKAY = 2'h0;
   localparam logic [1:0] TLA_RESP_SLVERR = 2'h2;

   // ==========================================================================
   // Bus state machines
   typedef enum logic [1:0] {TLA_WR_COLLECT = 2'b01, TLA_WR_RESP = 2'b10} tla_wr_t;
   typedef enum logic [1:0] {TLA_RD_IDLE = 2'b01, TLA_RD_RESP = 2'b10} tla_rd_t;

   // Consecutive faults needed for each filter code
   function automatic logic [2:0] tla_fault_need(input logic [1:0] sel);
      logic [2:0] need;
      need = 3'h1;
      case (sel)
         2'h1: need = 3'h2;
         2'h2: need = 3'h4;
         2'h3: need = 3'h6;
         default: need = 3'h1;
      endcase
      return need;
   endfunction : tla_fault_need

   // True where a bank and index land on a register
   function automatic logic tla_mapped(input logic [2:0] bank, input logic [6:0] idx);
      logic hit;
      hit = 1'b0;
      if (idx == TLA_IDX_BANK_SEL) begin
         hit = 1'b1;
      end else if (bank == TLA_BANK_CPU || bank == TLA_BANK_AUX) begin
         hit = (idx >= TLA_IDX_READ_HI) && (idx <= TLA_IDX_OVT_LO);
      end else if (bank == TLA_BANK_EVENT) begin
         hit = (idx == TLA_IDX_EVT_STATUS) || (idx == TLA_IDX_SMI_MASK) ||
               (idx == TLA_IDX_ALARM3);
      end else if (bank == TLA_BANK_GLOBAL) begin
         hit = (idx == TLA_IDX_ALARM2);
      end
      return hit;
   endfunction : tla_mapped

endpackage : tla_pkg

/* File: core/tla_channel.sv */
// One thermal channel: reading capture, fault filter, limit flag and alarm pin
`timescale 1ns/1ps
`default_nettype none
module tla_channel
   import tla_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic conv_valid,
   input wire logic [8:0] conv_temp,
   input wire logic stop_monitor,
   input wire logic irq_mode,
   input wire logic [1:0] fault_sel,
   input wire logic [8:0] hyst_limit,
   input wire logic [8:0] ovt_limit,
   input wire logic status_read,
   output logic [8:0] reading,
   output logic over_temperature_output_n
);

   // ==========================================================================
   // State
   typedef struct packed {
      logic [8:0] reading;
      logic [2:0] faults;
      logic flag;
      logic latch;
      logic ovt_n;
   } tla_chan_t;

   tla_chan_t s;
   tla_chan_t next_s;
   logic [2:0] need;

   assign need = tla_fault_need(fault_sel);

   // Conversions are ignored entirely while stopped, so the filter does not age
   always_comb begin
      next_s = s;
      if (conv_valid && !stop_monitor) begin
         next_s.reading = conv_temp;
         if (conv_temp > ovt_limit) begin
            if (s.faults < need) begin
               next_s.faults = s.faults + 3'h1;
            end
            if ((s.faults + 3'h1) >= need) begin
               next_s.flag = 1'b1;
            end
         end else begin
            next_s.faults = 3'h0;
            if (conv_temp < hyst_limit) begin
               next_s.flag = 1'b0;
            end
         end
      end
      // A fresh trip in the same cycle as the status read still latches
      if (status_read) begin
         next_s.latch = 1'b0;
      end
      if (!s.flag && next_s.flag) begin
         next_s.latch = 1'b1;
      end
      next_s.ovt_n = !(irq_mode ? next_s.latch : next_s.flag);
   end

   // Register the whole state
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s <= '{reading: TLA_READING_RST, faults: 3'h0, flag: 1'b0, latch: 1'b0,
                ovt_n: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign reading = s.reading;
   assign over_temperature_output_n = s.ovt_n;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_stop_freeze: assert property (stop_monitor |=> $stable(reading))
      else $error("reading changed while monitoring stopped");
   chk_single_fault: assert property (
      fault_sel == 2'h0 && conv_valid && !stop_monitor && conv_temp > ovt_limit |=> s.flag)
      else $error("single fault did not set the flag");
   chk_count_reset: assert property (
      conv_valid && !stop_monitor && conv_temp <= ovt_limit |=> s.faults == 3'h0)
      else $error("fault count not cleared by in-limit conversion");
   chk_hyst_clear: assert property (
      conv_valid && !stop_monitor && conv_temp <= ovt_limit && conv_temp < hyst_limit
      |=> !s.flag)
      else $error("flag not cleared below hysteresis");
   chk_cmp_follow: assert property (
      !$past(irq_mode) |-> over_temperature_output_n == !s.flag)
      else $error("comparator pin does not follow the flag");
   chk_irq_hold: assert property (
      irq_mode && s.latch && !status_read |=> !over_temperature_output_n)
      else $error("interrupt pin released without a status read");

endmodule : tla_channel
`default_nettype wire

/* File: core/tla_thermal_regs.sv */
// Banked register file behind AXI4-Lite with two thermal channels and alarm logic
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Overview of operation
// - Nine-bit reading, high byte plus half-degree bit
// - Config bits 4:3 select fault filter count
// - Config bit 1 picks comparator or interrupt
// - Config bit 0 stops channel monitoring
// - Nine-bit hysteresis limit, default 75 degrees
// - Nine-bit over-temperature limit, high resets 50h
// - Limit low bytes reset 00h, bit 7 only
// - Auxiliary channel mirrors layout in bank 2
// - Status bit 2 flags auxiliary fan warning
// - Status bits 1, 0 flag battery, standby
// - Status register read-only, bank 4, resets 00h
// - Mask bits 4, 1, 0 gate management interrupt
// - User alarm bit forces tone continuously
// - Battery and standby limits may sound tone
// - Bank select bits 2:0 map the window
// - Flag sets above limit, clears below hysteresis
// - Global tone enable defaults on, silences all
module tla_thermal_regs
   import tla_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [TLA_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [TLA_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic processor_conv_valid,
   input wire logic [8:0] processor_conv_temp,
   input wire logic auxiliary_conv_valid,
   input wire logic [8:0] auxiliary_conv_temp,
   input wire logic aux_fan_warning_event,
   input wire logic battery_limit_event,
   input wire logic standby_rail_limit_event,
   output logic processor_over_temperature_output_n,
   output logic auxiliary_over_temperature_output_n,
   output logic system_management_irq_n,
   output logic alarm_tone_output
);

   // ==========================================================================
   // State
   typedef struct packed {
      tla_wr_t wr_state;
      tla_rd_t rd_state;
      logic aw_got;
      logic w_got;
      logic [6:0] waddr;
      logic [7:0] wdata;
      logic wbyte;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [2:0] bank;
      logic [1:0][3:0] cfg;
      logic [1:0][8:0] hyst;
      logic [1:0][8:0] ovt;
      logic [2:0] status;
      logic [2:0] mask;
      logic user_force;
      logic bat_en;
      logic sb_en;
      logic global_en;
      logic smi_n;
      logic tone;
   } tla_regs_t;

   tla_regs_t s;
   tla_regs_t next_s;
   logic [6:0] ri;
   logic rc;
   logic wc;
   logic rd_hs;
   logic do_write;
   logic [7:0] rd_val;
   logic [1:0] chan_status_read;
   logic clr_status;
   logic [1:0] conv_valid_v;
   logic [1:0][8:0] conv_temp_v;
   logic [1:0][8:0] reading_v;
   logic [1:0] ovt_n_v;

   assign conv_valid_v = {auxiliary_conv_valid, processor_conv_valid};
   assign conv_temp_v = {auxiliary_conv_temp, processor_conv_temp};

   // ==========================================================================
   // Thermal channels: index 0 is the processor, 1 the auxiliary sensor
   genvar ch;
   generate
      for (ch = 0; ch < TLA_NUM_CH; ch++) begin : g_chan
         tla_channel u_chan (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .conv_valid(conv_valid_v[ch]),
            .conv_temp(conv_temp_v[ch]),
            .stop_monitor(s.cfg[ch][TLA_CFG_STOP_BIT]),
            .irq_mode(s.cfg[ch][TLA_CFG_MODE_BIT]),
            .fault_sel(s.cfg[ch][3:2]),
            .hyst_limit(s.hyst[ch]),
            .ovt_limit(s.ovt[ch]),
            .status_read(chan_status_read[ch]),
            .reading(reading_v[ch]),
            .over_temperature_output_n(ovt_n_v[ch])
         );
      end
   endgenerate

   // ==========================================================================
   // Read decode; the bank in force at the address handshake picks the target
   always_comb begin
      ri = s_axi_araddr[8:2];
      rc = (s.bank == TLA_BANK_AUX);
      rd_hs = s_axi_arvalid && s.arready;
      rd_val = 8'h00;
      chan_status_read = 2'b00;
      clr_status = 1'b0;
      if (ri == TLA_IDX_BANK_SEL) begin
         rd_val[2:0] = s.bank;
      end else if (s.bank == TLA_BANK_CPU || s.bank == TLA_BANK_AUX) begin
         case (ri)
            TLA_IDX_READ_HI: rd_val = reading_v[rc][8:1];
            TLA_IDX_READ_LO: rd_val[TLA_LO_BYTE_BIT] = reading_v[rc][0];
            TLA_IDX_CFG: begin
               rd_val[TLA_CFG_FAULT_LSB +: 2] = s.cfg[rc][3:2];
               rd_val[TLA_CFG_MODE_BIT] = s.cfg[rc][TLA_CFG_MODE_BIT];
               rd_val[TLA_CFG_STOP_BIT] = s.cfg[rc][TLA_CFG_STOP_BIT];
               chan_status_read[rc] = rd_hs;
            end
            TLA_IDX_HYST_HI: rd_val = s.hyst[rc][8:1];
            TLA_IDX_HYST_LO: rd_val[TLA_LO_BYTE_BIT] = s.hyst[rc][0];
            TLA_IDX_OVT_HI: rd_val = s.ovt[rc][8:1];
            TLA_IDX_OVT_LO: rd_val[TLA_LO_BYTE_BIT] = s.ovt[rc][0];
            default: rd_val = 8'h00;
         endcase
      end else if (s.bank == TLA_BANK_EVENT) begin
         case (ri)
            TLA_IDX_EVT_STATUS: begin
               rd_val[2:0] = s.status;
               clr_status = rd_hs;
            end
            TLA_IDX_SMI_MASK: begin
               rd_val[TLA_MASK_FAN_BIT] = s.mask[2];
               rd_val[1:0] = s.mask[1:0];
            end
            TLA_IDX_ALARM3: begin
               rd_val[TLA_ALARM_USER_BIT] = s.user_force;
               rd_val[TLA_ALARM_BAT_BIT] = s.bat_en;
               rd_val[TLA_ALARM_SB_BIT] = s.sb_en;
            end
            default: rd_val = 8'h00;
         endcase
      end else if (s.bank == TLA_BANK_GLOBAL && ri == TLA_IDX_ALARM2) begin
         rd_val[TLA_ALARM_GLOBAL_BIT] = s.global_en;
      end
   end

   // ==========================================================================
   // Next state: bus channels, register writes, event capture and outputs
   always_comb begin
      next_s = s;
      wc = (s.bank == TLA_BANK_AUX);
      do_write = 1'b0;
      // Write address and data are taken independently, in either order
      unique case (s.wr_state)
         TLA_WR_COLLECT: begin
            if (s_axi_awvalid && s.awready) begin
               next_s.aw_got = 1'b1;
               next_s.waddr = s_axi_awaddr[8:2];
               next_s.awready = 1'b0;
            end
            if (s_axi_wvalid && s.wready) begin
               next_s.w_got = 1'b1;
               next_s.wdata = s_axi_wdata[7:0];
               next_s.wbyte = s_axi_wstrb[0];
               next_s.wready = 1'b0;
            end
            if (next_s.aw_got && next_s.w_got) begin
               do_write = next_s.wbyte && tla_mapped(s.bank, next_s.waddr);
               next_s.bresp = tla_mapped(s.bank, next_s.waddr) ? TLA_RESP_OKAY
                                                               : TLA_RESP_SLVERR;
               next_s.bvalid = 1'b1;
               next_s.aw_got = 1'b0;
               next_s.w_got = 1'b0;
               next_s.wr_state = TLA_WR_RESP;
            end
         end
         TLA_WR_RESP: begin
            if (s_axi_bready) begin
               next_s.bvalid = 1'b0;
               next_s.awready = 1'b1;
               next_s.wready = 1'b1;
               next_s.wr_state = TLA_WR_COLLECT;
            end
         end
      endcase
      // Register writes; writes to read-only locations are dropped quietly
      if (do_write) begin
         if (next_s.waddr == TLA_IDX_BANK_SEL) begin
            next_s.bank = next_s.wdata[2:0];
         end else if (s.bank == TLA_BANK_CPU || s.bank == TLA_BANK_AUX) begin
            case (next_s.waddr)
               TLA_IDX_CFG: begin
                  // Reserved bits are not stored and read back as zero
                  next_s.cfg[wc] = {next_s.wdata[TLA_CFG_FAULT_LSB +: 2],
                                    next_s.wdata[TLA_CFG_MODE_BIT],
                                    next_s.wdata[TLA_CFG_STOP_BIT]};
               end
               TLA_IDX_HYST_HI: next_s.hyst[wc][8:1] = next_s.wdata;
               TLA_IDX_HYST_LO: next_s.hyst[wc][0] = next_s.wdata[TLA_LO_BYTE_BIT];
               TLA_IDX_OVT_HI: next_s.ovt[wc][8:1] = next_s.wdata;
               TLA_IDX_OVT_LO: next_s.ovt[wc][0] = next_s.wdata[TLA_LO_BYTE_BIT];
               default: next_s.bank = s.bank;
            endcase
         end else if (s.bank == TLA_BANK_EVENT) begin
            if (next_s.waddr == TLA_IDX_SMI_MASK) begin
               next_s.mask = {next_s.wdata[TLA_MASK_FAN_BIT], next_s.wdata[1:0]};
            end else if (next_s.waddr == TLA_IDX_ALARM3) begin
               next_s.user_force = next_s.wdata[TLA_ALARM_USER_BIT];
               next_s.bat_en = next_s.wdata[TLA_ALARM_BAT_BIT];
               next_s.sb_en = next_s.wdata[TLA_ALARM_SB_BIT];
            end
         end else if (next_s.waddr == TLA_IDX_ALARM2) begin
            next_s.global_en = next_s.wdata[TLA_ALARM_GLOBAL_BIT];
         end
      end
      // Read channel answers one cycle after the address is taken
      unique case (s.rd_state)
         TLA_RD_IDLE: begin
            if (rd_hs) begin
               next_s.rdata = rd_val;
               next_s.rresp = tla_mapped(s.bank, ri) ? TLA_RESP_OKAY : TLA_RESP_SLVERR;
               next_s.rvalid = 1'b1;
               next_s.arready = 1'b0;
               next_s.rd_state = TLA_RD_RESP;
            end
         end
         TLA_RD_RESP: begin
            if (s_axi_rready) begin
               next_s.rvalid = 1'b0;
               next_s.arready = 1'b1;
               next_s.rd_state = TLA_RD_IDLE;
            end
         end
      endcase
      // Status clears on read, but an event in the same cycle is kept
      if (clr_status) begin
         next_s.status = TLA_STATUS_RST;
      end
      next_s.status[TLA_EVT_FAN_BIT] = next_s.status[TLA_EVT_FAN_BIT] |
                                       aux_fan_warning_event;
      next_s.status[TLA_EVT_BAT_BIT] = next_s.status[TLA_EVT_BAT_BIT] |
                                       battery_limit_event;
      next_s.status[TLA_EVT_SB_BIT] = next_s.status[TLA_EVT_SB_BIT] |
                                      standby_rail_limit_event;
      next_s.smi_n = !(|(next_s.status & ~next_s.mask));
      // Tone follows live limit levels, so reading the status does not mute it
      next_s.tone = next_s.global_en && (next_s.user_force ||
                    (next_s.bat_en && battery_limit_event) ||
                    (next_s.sb_en && standby_rail_limit_event));
   end

   // ==========================================================================
   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s <= '{wr_state: TLA_WR_COLLECT, rd_state: TLA_RD_IDLE, awready: 1'b1,
                wready: 1'b1, arready: 1'b1, bank: TLA_BANK_RST,
                cfg: {TLA_CFG_RST, TLA_CFG_RST}, hyst: {TLA_HYST_RST, TLA_HYST_RST},
                ovt: {TLA_OVT_RST, TLA_OVT_RST}, status: TLA_STATUS_RST,
                mask: TLA_MASK_RST, global_en: TLA_GLOBAL_RST, smi_n: 1'b1,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = {24'h000000, s.rdata};
   assign s_axi_rresp = s.rresp;
   assign processor_over_temperature_output_n = ovt_n_v[0];
   assign auxiliary_over_temperature_output_n = ovt_n_v[1];
   assign system_management_irq_n = s.smi_n;
   assign alarm_tone_output = s.tone;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence tla_bank_wr;
      s_axi_awvalid && s.awready && s_axi_wvalid && s.wready && s_axi_wstrb[0] &&
      s_axi_awaddr[8:2] == TLA_IDX_BANK_SEL;
   endsequence
   sequence tla_status_rd;
      rd_hs && ri == TLA_IDX_EVT_STATUS && s.bank == TLA_BANK_EVENT &&
      !aux_fan_warning_event && !battery_limit_event && !standby_rail_limit_event;
   endsequence

   chk_bank_write: assert property (
      tla_bank_wr |=> s_axi_bvalid && s.bank == $past(s_axi_wdata[2:0]))
      else $error("bank select write not applied");
   chk_status_clear: assert property (
      tla_status_rd |=> s_axi_rvalid && s.status == TLA_STATUS_RST)
      else $error("status not cleared by its read");
   chk_bat_sticky: assert property (battery_limit_event |=> s.status[TLA_EVT_BAT_BIT])
      else $error("battery event lost");
   chk_fan_sticky: assert property (aux_fan_warning_event |=> s.status[TLA_EVT_FAN_BIT])
      else $error("fan warning event lost");
   chk_smi_gate: assert property (
      system_management_irq_n == !(|(s.status & ~s.mask)))
      else $error("management interrupt does not match masked status");
   chk_user_tone: assert property (s.global_en && s.user_force |-> alarm_tone_output)
      else $error("user alarm did not force the tone");
   chk_global_mute: assert property (!s.global_en |-> !alarm_tone_output)
      else $error("tone active while globally disabled");

endmodule : tla_thermal_regs
`default_nettype wire

/* File: testbench/tb_thermal_limit_alarm_regs.sv */
// Self-checking bench for the thermal limit alarm register block
`timescale 1ns/1ps
`default_nettype none
module tb_thermal_limit_alarm_regs;
   logic core_clk = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic processor_conv_valid = 1'h0, auxiliary_conv_valid = 1'h0, aux_fan_warning_event = 1'h0;
   logic battery_limit_event = 1'h0, standby_rail_limit_event = 1'h0;
   logic [8:0] s_axi_awaddr = 9'h0, s_axi_araddr = 9'h0, processor_conv_temp = 9'h0;
   logic [8:0] auxiliary_conv_temp = 9'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, ovt_n;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic processor_over_temperature_output_n, auxiliary_over_temperature_output_n;
   logic system_management_irq_n, alarm_tone_output;
   int err_total = 0, check_count = 0;
   // Alarm pins, processor in bit 0
   assign ovt_n = {auxiliary_over_temperature_output_n, processor_over_temperature_output_n};
   tla_thermal_regs u_dut (.*);
   // Free-running 20 MHz clock
   initial forever #25 core_clk = ~core_clk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) $display("[FAIL] %s expected %h seen %h", nm, e, s);
      err_total += int'(s !== e);
   endtask : chk
   // Write; each channel is released on its own ready, so either order works
   task automatic wr(input logic [6:0] i, input logic [7:0] d);
      @(posedge core_clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {i, 2'h0, 24'h0, d, 4'h1};
      do begin
         @(posedge core_clk);
         {s_axi_awvalid, s_axi_wvalid} <=
            {s_axi_awvalid & !s_axi_awready, s_axi_wvalid & !s_axi_wready};
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", 32'h0, {30'h0, s_axi_bresp});
   endtask : wr
   // Read; e carries the response code above the data byte
   task automatic rd(input logic [6:0] i, input logic [9:0] e);
      @(posedge core_clk);
      {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, i, 2'h0};
      do begin
         @(posedge core_clk);
         s_axi_arvalid <= s_axi_arvalid & !s_axi_arready;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rd", {e[9:8], 22'h0, e[7:0]}, {s_axi_rresp, s_axi_rdata[29:0]});
   endtask : rd
   // One conversion on channel c; the pin is judged once its flop has settled
   task automatic conv(input int c, input logic [8:0] t, input logic e);
      @(posedge core_clk);
      {processor_conv_valid, auxiliary_conv_valid} <= {c == 1, c == 2};
      {processor_conv_temp, auxiliary_conv_temp} <= {t, t};
      @(posedge core_clk);
      {processor_conv_valid, auxiliary_conv_valid} <= 2'h0;
      @(posedge core_clk);
      chk("ovt", {31'h0, e}, {31'h0, ovt_n[c-1]});
   endtask : conv
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   task automatic t_regs;
      rd(7'h57, 10'h080);
      wr(7'h4E, 8'h01);
      rd(7'h55, 10'h050);
      rd(7'h53, 10'h04B);
      rd(7'h58, 10'h200);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_chan;
      wr(7'h52, 8'h0A);
      conv(1, 9'h0A1, 1'h1);
      conv(1, 9'h0A1, 1'h0);
      conv(1, 9'h090, 1'h0);
      rd(7'h52, 10'h00A);
      rd(7'h50, 10'h048);
      chk("ovt", 32'h1, {31'h0, ovt_n[0]});
      $display("t_chan done");
   endtask : t_chan
   // Auxiliary channel: stop freezes it, then code 0 trips on one fault
   task automatic t_aux;
      wr(7'h4E, 8'h02);
      wr(7'h52, 8'h01);
      conv(2, 9'h0A1, 1'h1);
      rd(7'h50, 10'h000);
      wr(7'h52, 8'h00);
      conv(2, 9'h0A1, 1'h0);
      conv(2, 9'h097, 1'h0);
      conv(2, 9'h095, 1'h1);
      rd(7'h51, 10'h080);
      $display("t_aux done");
   endtask : t_aux
   task automatic t_event;
      {battery_limit_event, aux_fan_warning_event, standby_rail_limit_event} <= 3'h7;
      wr(7'h4E, 8'h04);
      wr(7'h53, 8'h02);
      rd(7'h50, 10'h007);
      chk("tone", 32'h1, {31'h0, alarm_tone_output});
      chk("smi", 32'h1, {31'h0, system_management_irq_n});
      wr(7'h51, 8'h00);
      chk("smi", 32'h0, {31'h0, system_management_irq_n});
      // Battery source disabled, so only the user bit can hold the tone
      wr(7'h53, 8'h20);
      chk("tone", 32'h1, {31'h0, alarm_tone_output});
      {battery_limit_event, aux_fan_warning_event, standby_rail_limit_event} <= 3'h0;
      rd(7'h50, 10'h007);
      rd(7'h50, 10'h000);
      chk("smi", 32'h1, {31'h0, system_management_irq_n});
      wr(7'h4E, 8'h00);
      wr(7'h57, 8'h00);
      chk("tone", 32'h0, {31'h0, alarm_tone_output});
      rd(7'h57, 10'h000);
      $display("t_event done");
   endtask : t_event
   // Reset for six cycles, then the scenarios in turn
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'h1;
      t_regs();
      t_chan();
      t_aux();
      t_event();
      end_of_test();
   end
   // Watchdog: a hung handshake ends the run as a mismatch
   initial begin
      #150us;
      err_total++;
      end_of_test();
   end
endmodule : tb_thermal_limit_alarm_regs
`default_nettype wire
